/* include/pattern_pkg.sv */
// Purpose: constants and types of the pattern stimulus/response core
// Assumes: 32-bit register port, byte offsets, 20 MHz system clock
// Notes: rates in Msample/s, times in ns
package pattern_pkg;
	localparam int NCH = 32;
	localparam int AW  = 8;
	// register offsets
	localparam logic [AW-1:0] REG_CTRL  = 8'h00;
	localparam logic [AW-1:0] REG_DIV   = 8'h04;
	localparam logic [AW-1:0] REG_SOUT  = 8'h08;
	localparam logic [AW-1:0] REG_SOE   = 8'h0c;
	localparam logic [AW-1:0] REG_SIN   = 8'h10;
	localparam logic [AW-1:0] REG_DSEL  = 8'h14;
	localparam logic [AW-1:0] REG_NDLY  = 8'h18;
	localparam logic [AW-1:0] REG_RDLY  = 8'h1c;
	localparam logic [AW-1:0] REG_LAST  = 8'h20;
	localparam logic [AW-1:0] REG_MADDR = 8'h24;
	localparam logic [AW-1:0] REG_STIM  = 8'h28;
	localparam logic [AW-1:0] REG_STEN  = 8'h2c;
	localparam logic [AW-1:0] REG_RESP  = 8'h30;
	localparam logic [AW-1:0] REG_STAT  = 8'h34;
	localparam logic [AW-1:0] REG_ELIG  = 8'h38;
	// reset values
	localparam logic [7:0]     DIV_RST  = 8'h01;
	localparam logic [NCH-1:0] WORD_RST = 32'h0;
	// status fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_CNT  = 8;
	// rates and channel split
	localparam int MCLK_MHZ  = 100;
	localparam int RATE_FULL = 200;
	localparam int RATE_MID  = 100;
	localparam int RATE_LOW  = 20;
	localparam int CH_FULL   = 16;
	localparam int CH_MID    = 22;
	localparam logic [NCH-1:0] MASK_FULL = NCH'((64'h1 << CH_FULL) - 1);
	localparam logic [NCH-1:0] MASK_MID  = NCH'((64'h1 << CH_MID) - 1);
	// timing
	localparam int  CLK_NS        = 50;
	localparam real FIXED_DLY_NS  = 2.5;
	localparam int  FIXED_DLY_CYC = (FIXED_DLY_NS <= CLK_NS) ? 1 :
		int'(FIXED_DLY_NS / CLK_NS + 0.999);
	localparam int  RESP_STEP_NS  = 10;
	typedef enum logic [1:0] {
		SRC_COAX   = 2'b00,
		SRC_PORT_A = 2'b01,
		SRC_PORT_B = 2'b10,
		SRC_SPARE  = 2'b11
	} src_e;
	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} seq_e;
	typedef struct packed {
		logic [21:0] spare;
		src_e        clk_src;
		logic        trig_clk;
		logic        hw_trig;
		logic        fixed_dly;
		logic        inv_edge;
		logic        ddr;
		logic        slave;
		logic        abort;
		logic        start;
	} ctrl_s;
	typedef struct packed {
		logic           trig;
		logic           coax_clock;
		logic           port_b_clock_lane;
		logic           port_a_clock_lane;
		logic [NCH-1:0] lanes;
	} pins_s;
endpackage

/* logic/sync2.sv */
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: W at least one
// Notes: only the second stage is visible
`timescale 1ns/10ps
module sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_nrst,
	// data
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	if (W < 1)
	begin : g_bad
		$error("sync2 width must be positive");
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			meta_r <= '0;
			q_r    <= '0;
		end
		else
		begin
			meta_r <= i_d;
			q_r    <= meta_r;
		end
	end

	assign o_q = q_r;
endmodule

/* logic/sample_delay.sv */
// Purpose: delays the sampling event by 1 + N cycles plus optional fixed step
// Assumes: i_n held stable while ticks are in flight
// Notes: total delay is 1 + n (+ FIX when fixed step on)
`timescale 1ns/10ps
module sample_delay #(
	parameter int MAXN = 16,
	parameter int FIX  = 1
) (
	// clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_nrst,
	// event in and out
	input  wire logic                    i_tick,
	input  wire logic [$clog2(MAXN)-1:0] i_n,
	input  wire logic                    i_fixed,
	output logic                         o_tick
);
	localparam int L = MAXN + FIX;
	logic [L-1:0] sr_r;

	if (MAXN < 2 || FIX < 1)
	begin : g_bad
		$error("sample_delay needs MAXN >= 2 and FIX >= 1");
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
			sr_r <= '0;
		else
			sr_r <= {sr_r[L-2:0], i_tick};
	end

	// delays add: cycle count plus fixed step
	assign o_tick = i_fixed ? sr_r[i_n + FIX] : sr_r[i_n];

	delay_sum_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
		(i_tick && i_n == 3 && i_fixed) ##1 (i_n == 3 && i_fixed) [*4]
		|=> o_tick)
		else $error("combined delay not 1+n+fixed");
endmodule

/* logic/pattern_core.sv */
// Purpose: static and dynamic digital stimulus/response channel core
// Assumes: pins and link clocks are asynchronous, host port synchronous
// Notes: lanes 7:0 port_a_data_lane, 15:8 port_b_data_lane,
//   16 port_a_general_lane, 18:17 port_a_single_ended_io,
//   19 port_b_general_lane, 21:20 port_b_single_ended_io, 31:22 rs485
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module pattern_core
	import pattern_pkg::*;
#(
	parameter int DEPTH = 64,
	parameter int MAXN  = 16
) (
	// clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_nrst,
	// register port
	input  wire logic [pattern_pkg::AW-1:0]  i_addr,
	input  wire logic [31:0]             i_wdata,
	input  wire logic                    i_we,
	input  wire logic                    i_re,
	output logic      [31:0]             o_rdata,
	// channel pins
	input  wire logic [pattern_pkg::NCH-1:0] i_lane,
	output logic      [pattern_pkg::NCH-1:0] o_lane,
	output logic      [pattern_pkg::NCH-1:0] o_lane_oe,
	// clock and trigger pins
	input  wire logic                    i_port_a_clock_lane,
	input  wire logic                    i_port_b_clock_lane,
	input  wire logic                    i_coax_clock,
	input  wire logic                    i_trig,
	output logic                         o_port_a_clock_lane,
	output logic                         o_port_b_clock_lane,
	output logic                         o_coax_clock,
	output logic                         o_clock_oe
);
	import pattern_pkg::*;

	localparam int IW = $clog2(DEPTH);
	localparam int NW = $clog2(MAXN);

	if (DEPTH < 2 || (1 << IW) != DEPTH || MAXN < 2)
	begin : g_bad
		$error("DEPTH must be a power of two >= 2, MAXN >= 2");
	end

	ctrl_s          ctrl_r;
	ctrl_s          w_ctrl;
	logic [7:0]     div_r;
	logic [NCH-1:0] sout_r;
	logic [NCH-1:0] soe_r;
	logic [NCH-1:0] dsel_r;
	logic [NW-1:0]  ndly_r;
	logic [15:0]    rdly_r;
	logic [IW-1:0]  last_r;
	logic [IW-1:0]  maddr_r;
	logic [31:0]    rdata_r;
	logic [NCH-1:0] stim_mem [DEPTH];
	logic [NCH-1:0] sten_mem [DEPTH];
	logic [NCH-1:0] resp_mem [DEPTH];
	seq_e           state_r;
	logic [IW-1:0]  idx_r;
	logic [IW:0]    ridx_r;
	logic           done_r;
	logic           armed_r;
	logic [20:0]    acc_r;
	logic [7:0]     mcnt_r;
	logic           mclk_r;
	logic           ext_prev_r;
	logic           trig_prev_r;
	logic [NCH-1:0] lane_r;
	logic [NCH-1:0] oe_r;
	pins_s          pins_q;
	logic           ext_clk;
	logic           rise;
	logic           fall;
	logic           stim_tick;
	logic           samp_raw;
	logic           samp_tick;
	logic           start_p;
	logic           abort_p;
	logic           trig_rise;
	logic [15:0]    rate_num;
	logic [15:0]    lo_lim;
	logic [15:0]    mid_lim;
	logic [NCH-1:0] elig;
	logic           dis_ok;
	logic [NCH-1:0] dyn_mask;
	logic           capt;

	// pins cross into the system clock domain
	sync2 #(
		.W ($bits(pins_s))
	) u_sync (
		.i_clk  (i_clk),
		.i_nrst (i_nrst),
		.i_d    ({i_trig, i_coax_clock, i_port_b_clock_lane,
			i_port_a_clock_lane, i_lane}),
		.o_q    (pins_q)
	);

	// channel split by declared sample rate
	always_comb
	begin
		rate_num = ctrl_r.ddr ? 16'(RATE_FULL) : 16'(RATE_MID);
		lo_lim   = 16'(RATE_LOW) * {8'h00, div_r};
		mid_lim  = 16'(RATE_MID) * {8'h00, div_r};
		if (ctrl_r.ddr && div_r == 8'h01)
			elig = MASK_FULL;
		else if (rate_num > lo_lim)
			elig = MASK_MID;
		else
			elig = '1;
		dis_ok   = rate_num < mid_lim;
		dyn_mask = dsel_r & elig;
	end

	// master divider and clock output
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			mcnt_r <= 8'h00;
			mclk_r <= 1'b0;
		end
		else
		begin
			mclk_r <= ~mclk_r;
			if (mcnt_r >= div_r - 8'h01)
				mcnt_r <= 8'h00;
			else
				mcnt_r <= mcnt_r + 8'h01;
		end
	end

	always_comb
	begin
		unique case (ctrl_r.clk_src)
			SRC_PORT_A: ext_clk = pins_q.port_a_clock_lane;
			SRC_PORT_B: ext_clk = pins_q.port_b_clock_lane;
			default:    ext_clk = pins_q.coax_clock;
		endcase
		if (ctrl_r.trig_clk)
			ext_clk = pins_q.trig;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			ext_prev_r  <= 1'b0;
			trig_prev_r <= 1'b0;
		end
		else
		begin
			ext_prev_r  <= ext_clk;
			trig_prev_r <= pins_q.trig;
		end
	end

	always_comb
	begin
		if (ctrl_r.slave)
		begin
			rise = ext_clk & ~ext_prev_r;
			fall = ~ext_clk & ext_prev_r;
		end
		else
		begin
			rise = mcnt_r == 8'h00;
			fall = mcnt_r == (div_r >> 1);
		end
		stim_tick = rise | (ctrl_r.ddr & fall);
		samp_raw  = ctrl_r.ddr ? (rise | fall) :
			(ctrl_r.inv_edge ? fall : rise);
	end

	sample_delay #(
		.MAXN (MAXN),
		.FIX  (FIXED_DLY_CYC)
	) u_dly (
		.i_clk   (i_clk),
		.i_nrst  (i_nrst),
		.i_tick  (samp_raw),
		.i_n     (ndly_r),
		.i_fixed (ctrl_r.fixed_dly),
		.o_tick  (samp_tick)
	);

	// one trigger starts stimulus and capture
	assign w_ctrl    = ctrl_s'(i_wdata);
	assign trig_rise = pins_q.trig & ~trig_prev_r;
	assign start_p   = (i_we && i_addr == REG_CTRL && w_ctrl.start) ||
		(ctrl_r.hw_trig && !ctrl_r.trig_clk && trig_rise);
	assign abort_p   = i_we && i_addr == REG_CTRL && w_ctrl.abort;

	// register writes
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			ctrl_r  <= ctrl_s'(WORD_RST);
			div_r   <= DIV_RST;
			sout_r  <= WORD_RST;
			soe_r   <= WORD_RST;
			dsel_r  <= WORD_RST;
			ndly_r  <= '0;
			rdly_r  <= 16'h0000;
			last_r  <= '0;
			maddr_r <= '0;
		end
		else if (i_we)
		begin
			case (i_addr)
				REG_CTRL:
				begin
					ctrl_r       <= w_ctrl;
					ctrl_r.start <= 1'b0;
					ctrl_r.abort <= 1'b0;
				end
				REG_DIV:   div_r  <= (i_wdata[7:0] == 8'h00) ?
					DIV_RST : i_wdata[7:0];
				REG_SOUT:  sout_r <= i_wdata;
				REG_SOE:   soe_r  <= i_wdata;
				REG_DSEL:  dsel_r <= i_wdata;
				REG_NDLY:  ndly_r <= i_wdata[NW-1:0];
				REG_RDLY:  rdly_r <= i_wdata[15:0];
				REG_LAST:  last_r <= i_wdata[IW-1:0];
				REG_MADDR: maddr_r <= i_wdata[IW-1:0];
				REG_STEN:  maddr_r <= maddr_r + 1'b1;
				default:   ;
			endcase
		end
		else if (i_re && i_addr == REG_RESP)
			maddr_r <= maddr_r + 1'b1;
	end

	// stimulus memory loads only while idle
	always_ff @(posedge i_clk)
	begin
		if (i_we && state_r == ST_IDLE && i_addr == REG_STIM)
			stim_mem[maddr_r] <= i_wdata;
		if (i_we && state_r == ST_IDLE && i_addr == REG_STEN)
			sten_mem[maddr_r] <= i_wdata;
	end

	// register reads, data one cycle later
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
			rdata_r <= 32'h0;
		else if (!i_re)
			rdata_r <= 32'h0;
		else
		begin
			case (i_addr)
				REG_CTRL:  rdata_r <= ctrl_r;
				REG_DIV:   rdata_r <= {24'h0, div_r};
				REG_SOUT:  rdata_r <= sout_r;
				REG_SOE:   rdata_r <= soe_r;
				REG_SIN:   rdata_r <= pins_q.lanes;
				REG_DSEL:  rdata_r <= dsel_r;
				REG_NDLY:  rdata_r <= 32'(ndly_r);
				REG_RDLY:  rdata_r <= {16'h0, rdly_r};
				REG_LAST:  rdata_r <= 32'(last_r);
				REG_MADDR: rdata_r <= 32'(maddr_r);
				REG_STIM:  rdata_r <= stim_mem[maddr_r];
				REG_STEN:  rdata_r <= sten_mem[maddr_r];
				REG_RESP:  rdata_r <= resp_mem[maddr_r];
				REG_STAT:  rdata_r <= (32'(ridx_r) << STAT_CNT) |
					(32'(done_r) << STAT_DONE) |
					(32'(state_r == ST_RUN) << STAT_BUSY);
				REG_ELIG:  rdata_r <= elig;
				default:   rdata_r <= 32'h0;
			endcase
		end
	end

	// pattern sequencer
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			state_r <= ST_IDLE;
			idx_r   <= '0;
			done_r  <= 1'b0;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:
					if (start_p)
					begin
						state_r <= ST_RUN;
						idx_r   <= '0;
						done_r  <= 1'b0;
					end
				ST_RUN:
					if (abort_p)
						state_r <= ST_IDLE;
					else if (stim_tick && idx_r == last_r)
					begin
						state_r <= ST_IDLE;
						done_r  <= 1'b1;
					end
					else if (stim_tick)
						idx_r <= idx_r + 1'b1;
			endcase
		end
	end

	// response delay in 10 ns steps from the trigger
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			acc_r   <= 21'h0;
			armed_r <= 1'b0;
		end
		else if (start_p && state_r == ST_IDLE)
		begin
			acc_r   <= 21'h0;
			armed_r <= rdly_r == 16'h0000;
		end
		else if (state_r == ST_RUN && !armed_r)
		begin
			acc_r   <= acc_r + 21'(CLK_NS);
			armed_r <= acc_r + 21'(CLK_NS) >=
				21'(rdly_r) * 21'(RESP_STEP_NS);
		end
	end

	// capture, bounded by the run and the memory depth
	assign capt = state_r == ST_RUN && armed_r && samp_tick &&
		ridx_r < (IW+1)'(DEPTH);

	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
			ridx_r <= '0;
		else if (start_p && state_r == ST_IDLE)
			ridx_r <= '0;
		else if (capt)
			ridx_r <= ridx_r + 1'b1;
	end

	always_ff @(posedge i_clk)
	begin
		if (capt)
			resp_mem[ridx_r[IW-1:0]] <= pins_q.lanes;
	end

	// output drive
	always_ff @(posedge i_clk)
	begin
		if (!i_nrst)
		begin
			lane_r <= WORD_RST;
			oe_r   <= WORD_RST;
		end
		else if (state_r == ST_RUN)
		begin
			lane_r <= (stim_mem[idx_r] & dyn_mask) |
				(sout_r & ~dyn_mask);
			oe_r   <= ((dis_ok ? sten_mem[idx_r] : '1) & dyn_mask) |
				(soe_r & ~dyn_mask);
		end
		else
		begin
			lane_r <= sout_r;
			oe_r   <= soe_r;
		end
	end

	assign o_rdata             = rdata_r;
	assign o_lane              = lane_r;
	assign o_lane_oe           = oe_r;
	assign o_port_a_clock_lane = mclk_r;
	assign o_port_b_clock_lane = mclk_r;
	assign o_coax_clock        = mclk_r;
	assign o_clock_oe          = ~ctrl_r.slave;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_nrst);

	elig_full_a: assert property (ctrl_r.ddr && div_r == 8'h01
		|-> elig == 32'h0000ffff)
		else $error("full rate split wrong");
	elig_mid_a: assert property (!ctrl_r.ddr && div_r <= 8'h04
		|-> elig == 32'h003fffff)
		else $error("mid rate split wrong");
	elig_low_a: assert property (!ctrl_r.ddr && div_r == 8'h05
		|-> elig == 32'hffffffff)
		else $error("low rate split wrong");
	static_out_a: assert property (i_we && i_addr == REG_SOUT &&
		state_r == ST_IDLE && !start_p ##1 !start_p && !i_we
		|=> o_lane == $past(i_wdata, 2))
		else $error("static write not applied");
	run_end_a: assert property (state_r == ST_RUN && !abort_p &&
		stim_tick && idx_r == last_r |=> state_r == ST_IDLE && done_r)
		else $error("run did not end after last pattern");
	abort_a: assert property (state_r == ST_RUN && abort_p
		|=> state_r == ST_IDLE && !done_r)
		else $error("abort ignored");
	start_a: assert property (state_r == ST_IDLE && start_p
		|=> state_r == ST_RUN && idx_r == '0 && ridx_r == '0)
		else $error("start not common to stimulus and capture");
	clk_out_a: assert property (1'b1 |=>
		o_coax_clock != $past(o_coax_clock) &&
		o_port_a_clock_lane == o_coax_clock)
		else $error("clock output not toggling");
	dyn_oe_a: assert property (state_r == ST_RUN && !dis_ok
		|=> (o_lane_oe & $past(dyn_mask)) == $past(dyn_mask))
		else $error("dynamic disable above limit");
	no_capt_idle_a: assert property (state_r == ST_IDLE
		|=> $stable(ridx_r) || $past(start_p))
		else $error("capture outside run");

	run_done_c: cover property (state_r == ST_RUN ##1 done_r);
	abort_c: cover property (state_r == ST_RUN && abort_p);
	capt_c: cover property (capt ##[1:20] capt);
	slave_c: cover property (ctrl_r.slave && rise);
endmodule

/* tb/uut_model.sv */
// Purpose: unit under test and link clock beside the pattern core
// Assumes: each end drives only the lanes it enables
// Notes: link clock runs only while i_clk_run is high
`timescale 1ns/10ps
module uut_model
	import pattern_pkg::*;
(
	// lanes from the core
	input  wire logic [pattern_pkg::NCH-1:0] i_lane,
	input  wire logic [pattern_pkg::NCH-1:0] i_lane_oe,
	// link clock control
	input  wire logic                        i_clk_run,
	input  wire logic [1:0]                  i_clk_sel,
	// lane level and link clocks
	output logic      [pattern_pkg::NCH-1:0] o_wire,
	output logic                             o_coax_clock,
	output logic                             o_port_a_clock_lane,
	output logic                             o_port_b_clock_lane,
	output logic                             o_trig_clock
);
	logic link_clk;
	// free lanes answer a scramble of the driven ones
	function automatic logic [NCH-1:0] answer(input logic [NCH-1:0] d, oe);
		logic [NCH-1:0] v;
		v = d & oe;
		return v | (~oe & ({v[NCH-2:0], v[NCH-1]} ^ 32'h3c3c_a5a5));
	endfunction
	assign o_wire = answer(i_lane, i_lane_oe);
	// still at 0 outside a run
	initial
	begin
		link_clk = 1'b0;
		#37;
		forever
		begin
			#200;
			link_clk = i_clk_run ? ~link_clk : 1'b0;
		end
	end
	assign o_coax_clock        = link_clk && i_clk_sel == 2'b00;
	assign o_port_a_clock_lane = link_clk && i_clk_sel == 2'b01;
	assign o_port_b_clock_lane = link_clk && i_clk_sel == 2'b10;
	// select 3: slow slave clock arrives on the trigger pin
	assign o_trig_clock        = link_clk && i_clk_sel == 2'b11;
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench for the pattern core
// Assumes: 20 MHz clock, 400 ns link clock from the unit model
// Notes: bench keeps register copies and per-run pattern tables
`timescale 1ns/10ps
module tb_top;
	import pattern_pkg::*;
	logic           i_clk, i_nrst, i_we, i_re, i_trig, mon_on;
	logic [AW-1:0]  i_addr;
	logic [31:0]    i_wdata, o_rdata, sout, soe;
	logic [NCH-1:0] o_lane, o_lane_oe, wire_lvl;
	logic           ca, cb, cx, oa, ob, oc, o_clock_oe, clk_run, tc;
	logic [1:0]     clk_sel;
	logic [31:0]    q_ln[0:17], q_oe[0:17];
	int             err_count, checks_done, cycles, mj, last;
	ctrl_s          cw;
	// div ddr n inv fix rdly slave src(3 = trigger pin) hw
	int cfg[8][9] = '{'{5,0,0,0,0,0,0,0,0}, '{1,1,2,0,1,3,0,0,0},
		'{1,0,4,1,0,12,0,0,0}, '{8,0,3,1,1,5,0,0,1},
		'{5,0,1,0,0,0,1,0,0}, '{5,0,0,1,0,2,1,1,0}, '{5,0,2,0,1,0,1,2,0},
		'{5,0,1,0,0,0,1,3,0}};
	int etab[6][2] = '{'{1,1}, '{2,1}, '{1,0}, '{4,0}, '{5,0}, '{255,0}};
	pattern_core #(.DEPTH(64), .MAXN(16)) u_dut (
		.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
		.i_lane(wire_lvl), .o_lane(o_lane), .o_lane_oe(o_lane_oe),
		.i_port_a_clock_lane(ca), .i_port_b_clock_lane(cb),
		.i_coax_clock(cx), .i_trig(i_trig | tc), .o_port_a_clock_lane(oa),
		.o_port_b_clock_lane(ob), .o_coax_clock(oc),
		.o_clock_oe(o_clock_oe));
	uut_model u_uut (
		.i_lane(o_lane), .i_lane_oe(o_lane_oe), .i_clk_run(clk_run),
		.i_clk_sel(clk_sel), .o_wire(wire_lvl), .o_coax_clock(cx),
		.o_port_a_clock_lane(ca), .o_port_b_clock_lane(cb),
		.o_trig_clock(tc));
	initial i_clk = 1'b0;
	always #25 i_clk = ~i_clk;
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_we <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_re <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_re <= 1'b0;
		#1 d = o_rdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, string nm);
		logic [31:0] d;
		rd(a, d);
		chk(nm, d, e);
	endtask
	function automatic logic [31:0] elig(input int div, ddr);
		int r;
		r = MCLK_MHZ / div * (ddr + 1);
		return r > RATE_MID ? MASK_FULL : r > RATE_LOW ? MASK_MID : '1;
	endfunction
	function automatic logic seen_ok(input int j);
		return o_lane_oe === q_oe[j] && (o_lane & q_oe[j]) === q_ln[j];
	endfunction
	// pattern order follower while a run is live
	always @(posedge i_clk)
		if (mon_on && !seen_ok(mj))
		begin
			if (mj < last + 2 && seen_ok(mj + 1))
				mj++;
			else
			begin
				chk("lane_seq", {o_lane_oe, o_lane}, {q_oe[mj], q_ln[mj]});
				mon_on = 1'b0;
			end
		end
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic run(input int c[9]);
		logic [31:0] dm, st, en, d;
		int r, k, j;
		r = MCLK_MHZ / c[0] * (c[1] + 1);
		dm = elig(c[0], c[1]) & ($urandom | 32'hf);
		last = 11;
		sout = $urandom;
		sout[0] = 1'b0;
		soe = $urandom;
		soe[0] = 1'b1;
		wr(REG_SOUT, sout);
		wr(REG_SOE, soe);
		wr(REG_DSEL, dm);
		wr(REG_DIV, c[0]);
		wr(REG_NDLY, c[2]);
		wr(REG_RDLY, c[5]);
		wr(REG_LAST, last);
		wr(REG_MADDR, 0);
		q_oe[0] = soe;
		q_ln[0] = sout & soe;
		for (k = 1; k <= last + 1; k++)
		begin
			st = $urandom;
			st[0] = k[0];
			en = $urandom | 32'h1;
			wr(REG_STIM, st);
			wr(REG_STEN, en);
			if (r >= RATE_MID)
				en = '1;
			q_oe[k] = soe & ~dm | en & dm;
			q_ln[k] = (sout & ~dm | st & dm) & q_oe[k];
		end
		q_oe[last + 2] = q_oe[0];
		q_ln[last + 2] = q_ln[0];
		cw = '0;
		cw.ddr = c[1][0];
		cw.inv_edge = c[3][0];
		cw.fixed_dly = c[4][0];
		cw.slave = c[6][0];
		cw.clk_src = src_e'(c[7]);
		cw.trig_clk = c[7] == 3;
		cw.hw_trig = c[8][0];
		cw.start = !c[8][0];
		clk_sel <= c[7][1:0];
		mj = 0;
		mon_on = 1'b1;
		wr(REG_CTRL, cw);
		clk_run <= c[6][0];
		if (c[8])
		begin
			i_trig <= 1'b1;
			repeat (4) @(posedge i_clk);
			i_trig <= 1'b0;
		end
		#1 chk("clock_oe", o_clock_oe, !c[6]);
		k = 0;
		do rd(REG_STAT, d); while (d[STAT_DONE] !== 1'b1 && ++k < 300);
		clk_run <= 1'b0;
		mon_on = 1'b0;
		chk("run_end", d[1:0], 2'b10);
		chk("all_out", mj > last, 1);
		j = d >> STAT_CNT;
		chk("cap_cnt", j >= 1 && j <= last + 1, 1);
		if (j > last + 1)
			j = 0;
		wr(REG_MADDR, 0);
		k = 0;
		repeat (j)
		begin
			rd(REG_RESP, d);
			while (k <= last + 2 && d !== u_uut.answer(q_ln[k], q_oe[k]))
				k++;
			chk("resp", k <= last + 2, 1);
		end
		$display("test run %0d %0d done", c[0], c[6]);
	endtask
	initial
	begin
		logic [31:0] d;
		void'($urandom(65));
		{i_nrst, i_we, i_re, i_trig, clk_run, mon_on} = '0;
		{i_addr, i_wdata, clk_sel, cycles, err_count, checks_done} = '0;
		repeat (10) @(posedge i_clk);
		i_nrst <= 1'b1;
		rc(REG_DIV, DIV_RST, "div_rst");
		rc(REG_SOUT, WORD_RST, "sout_rst");
		rc(REG_STAT, 0, "stat_rst");
		rc(8'hfc, 0, "unmapped");
		chk("oe_rst", {o_lane_oe, o_clock_oe}, {32'h0, 1'b1});
		repeat (4)
		begin
			d[0] = oa;
			@(posedge i_clk);
			#1 chk("clk_out", {oa, ob, oc}, {3{~d[0]}});
		end
		$display("test reset done");
		repeat (6)
		begin
			sout = $urandom;
			soe = $urandom;
			wr(REG_SOE, soe);
			wr(REG_SOUT, ~sout);
			wr(REG_SOUT, sout);
			repeat (3) @(posedge i_clk);
			#1 chk("static_oe", o_lane_oe, soe);
			chk("static_out", o_lane & soe, sout & soe);
			rc(REG_SIN, u_uut.answer(sout, soe), "sin");
		end
		$display("test static done");
		foreach (etab[k])
		begin
			wr(REG_DIV, etab[k][0]);
			cw = '0;
			cw.ddr = etab[k][1][0];
			wr(REG_CTRL, cw);
			d = elig(etab[k][0], etab[k][1]);
			rc(REG_ELIG, d, "elig");
		end
		wr(REG_DIV, 0);
		rc(REG_DIV, 1, "div_zero");
		$display("test split done");
		foreach (cfg[k])
			run(cfg[k]);
		wr(REG_DIV, 255);
		wr(REG_LAST, 15);
		cw = '0;
		cw.start = 1'b1;
		wr(REG_CTRL, cw);
		rd(REG_STAT, d);
		chk("busy", d[1:0], 2'b01);
		cw = '0;
		cw.abort = 1'b1;
		wr(REG_CTRL, cw);
		rd(REG_STAT, d);
		chk("abort", d[1:0], 2'b00);
		$display("test abort done");
		report_and_stop();
	end
endmodule
